// File: pkg/wit_pkg.sv
package wit_pkg;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0]  WIT_CNT_RESET    = 8'h00;  // Counter after reset
   localparam logic [7:0]  WIT_RCTL_RESET   = 8'h1f;  // Reset control after pin reset
   localparam logic [2:0]  WIT_CKS_RESET    = 3'h0;   // Clock select after reset

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int WIT_OVF_BIT  = 7;   // Overflow flag
   localparam int WIT_MODE_BIT = 6;   // Mode select
   localparam int WIT_EN_BIT   = 5;   // Count enable
   localparam int WIT_WDOVF_BIT = 7;  // Watchdog overflow flag
   localparam int WIT_RSTEN_BIT = 6;  // Reset enable
   localparam int WIT_RTYPE_BIT = 5;  // Reset type select
   localparam logic [1:0] WIT_CTRL_RSVD = 2'h3;   // Bits 4..3 read one
   localparam logic [4:0] WIT_RCTL_RSVD = 5'h1f;  // Bits 4..0 read one

   // ----------------------------------------------------------------
   // Register select codes and write keys (upper byte of a word write)
   // ----------------------------------------------------------------
   localparam logic [1:0] WIT_SEL_CSR  = 2'h0;   // Control/status, shared write slot
   localparam logic [1:0] WIT_SEL_CNT  = 2'h1;   // Counter read slot
   localparam logic [1:0] WIT_SEL_RST  = 2'h2;   // Reset control/status
   localparam logic [7:0] WIT_KEY_CNT  = 8'h5a;  // Word write goes to counter
   localparam logic [7:0] WIT_KEY_CSR  = 8'ha5;  // Word write goes to control/status
   localparam logic [7:0] WIT_KEY_WDOVF = 8'ha5;  // Clears watchdog overflow flag
   localparam logic [7:0] WIT_KEY_RSTEN = 8'h5a;  // Writes reset enable and type

   // ----------------------------------------------------------------
   // Timing, in clock states (one state is one clk cycle)
   // ----------------------------------------------------------------
   localparam int WIT_RST_HOLD_STATES = 518;  // Internal reset width
   localparam int WIT_LOCK_STATES     = 132;  // Write lockout after overflow
   localparam int WIT_RST_HOLD_CYCLES = WIT_RST_HOLD_STATES * 1;
   localparam int WIT_LOCK_CYCLES     = WIT_LOCK_STATES * 1;
   localparam int WIT_TMR_W           = 10;   // Hold/lock timer width
   localparam int WIT_PRE_W           = 11;   // Prescaler width, largest tap /2048

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic       ovf;   // Overflow flag
      logic       mode;  // 1 watchdog, 0 interval
      logic       en;    // Count enable
      logic [2:0] cks;   // Clock select
   } wit_ctrl_type;

   typedef struct packed {
      logic wdovf;  // Watchdog overflow flag
      logic rsten;  // Reset enable
      logic rtype;  // Reset type select
   } wit_rctl_type;

   typedef struct packed {
      logic        rd;       // Read strobe
      logic        wr_word;  // Word write strobe
      logic        wr_byte;  // Byte write strobe, always ignored
      logic [1:0]  sel;      // Register select
      logic [15:0] wdata;    // Key in upper byte, data in lower byte
   } wit_bus_req_type;

   typedef enum logic [2:0] {
      WIT_ST_NORMAL = 3'b001,  // Counting, writes accepted
      WIT_ST_HOLD   = 3'b010,  // Internal chip reset asserted
      WIT_ST_LOCK   = 3'b100   // Writes refused after overflow
   } wit_state_type;

   localparam wit_ctrl_type WIT_CTRL_RESET = '{ovf: 1'b0, mode: 1'b0, en: 1'b0,
                                               cks: WIT_CKS_RESET};

endpackage

// File: design/wit_watchdog_unit.sv
`timescale 1ns/1ps
// Operation
// - Readable writable 8-bit counter increments on prescaled clock
// - Counter is zero after reset
// - Enable bit starts counter; clearing it zeroes
// - Wrap from all ones sets overflow flag in interval mode
// - Overflow flag clears after read-one then write-zero
// - Internal reset clears overflow flag automatically
// - Mode bit: zero interval, one watchdog
// - Interval mode raises interrupt on every overflow
// - Clock select codes 000/001/100 give /2,/64,/2048
// - Reserved bits read one, writes ignored
// - Watchdog flag sets on overflow only in watchdog
// - Watchdog flag clears after read-one then write-zero
// - Reset enable makes overflow reset the chip
// - Without reset enable, reset counter and control only
// - Reset type bit zero selects power-on reset; rtype is only stored and read back, chip_reset_q does not depend on it
// - Reset control keeps value through internal reset
// - Protected registers need keyed write sequence
// - Only word writes accepted, byte writes ignored
// - Internal reset held for 518 states
// - Pin reset wins and leaves watchdog flag clear
// - Counter write beats a coinciding increment
module wit_watchdog_unit
   import wit_pkg::*;
(
   input  wire logic             clk,             // System clock
   input  wire logic             resetn,          // External reset pin, active low
   input  wire wit_bus_req_type  bus_req,         // Register access request
   output logic      [7:0]       rdata_q,         // Read data, loaded on read strobe
   output logic                  chip_reset_q,    // Internal power-on reset request
   output logic                  interval_irq_q   // Interval interrupt level
);

   // ----------------------------------------------------------------
   // Prescaler tap decoding
   // ----------------------------------------------------------------
   function automatic logic [WIT_PRE_W-1:0] div_mask(input logic [2:0] cks);
      unique case (cks)
         3'h0:    div_mask = 11'h001;  // /2
         3'h1:    div_mask = 11'h03f;  // /64
         3'h2:    div_mask = 11'h007;  // /8
         3'h3:    div_mask = 11'h01f;  // /32
         3'h4:    div_mask = 11'h7ff;  // /2048
         3'h5:    div_mask = 11'h0ff;  // /256
         3'h6:    div_mask = 11'h1ff;  // /512
         default: div_mask = 11'h3ff;  // /1024
      endcase
   endfunction

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic [WIT_PRE_W-1:0] pre_q, pre_d;          // Free running prescaler
   logic [7:0]           cnt_q, cnt_d;          // Watchdog counter
   wit_ctrl_type         ctrl_q, ctrl_d;        // Timer control/status
   wit_rctl_type         rst_q, rst_d;          // Reset control/status
   logic                 ovf_arm_q, ovf_arm_d;  // Overflow seen as one by a read
   logic                 wdovf_arm_q;           // Watchdog flag seen as one
   logic                 wdovf_arm_d;           // Next watchdog flag arm
   wit_state_type        st_q, st_d;            // Overflow sequencing
   logic [WIT_TMR_W-1:0] tmr_q, tmr_d;          // Hold/lock timer
   logic [7:0]           rdata_d;               // Next read data
   logic                 chip_reset_d;          // Next reset request
   logic                 irq_d;                 // Next interrupt level

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   logic tick;      // Prescaled count pulse
   logic wr_ok;     // Word write while writes allowed
   logic cnt_wr;    // Counter write taken
   logic csr_wr;    // Control write taken
   logic wdovf_wr;  // Watchdog flag clear attempt
   logic rsten_wr;  // Reset enable/type write
   logic ovf_evt;   // Counter wraps this cycle
   logic wd_ovf;    // Wrap in watchdog mode
   logic [7:0] ctrl_rd;  // Control read image
   logic [7:0] rst_rd;   // Reset control read image

   // Prescaler tap and write qualification
   always_comb begin
      tick    = (pre_q & div_mask(ctrl_q.cks)) == div_mask(ctrl_q.cks);
      // Byte writes never qualify
      wr_ok   = bus_req.wr_word && (st_q == WIT_ST_NORMAL);
      cnt_wr  = wr_ok && bus_req.sel == WIT_SEL_CSR
                && bus_req.wdata[15:8] == WIT_KEY_CNT;
      csr_wr  = wr_ok && bus_req.sel == WIT_SEL_CSR
                && bus_req.wdata[15:8] == WIT_KEY_CSR;
      wdovf_wr = wr_ok && bus_req.sel == WIT_SEL_RST
                 && bus_req.wdata[15:8] == WIT_KEY_WDOVF;
      rsten_wr = wr_ok && bus_req.sel == WIT_SEL_RST
                 && bus_req.wdata[15:8] == WIT_KEY_RSTEN;
      // Write wins over a coinciding increment
      ovf_evt = ctrl_q.en && tick && !cnt_wr && cnt_q == 8'hff;
      wd_ovf  = ovf_evt && ctrl_q.mode;
      ctrl_rd = {ctrl_q.ovf, ctrl_q.mode, ctrl_q.en, WIT_CTRL_RSVD, ctrl_q.cks};
      rst_rd  = {rst_q.wdovf, rst_q.rsten, rst_q.rtype, WIT_RCTL_RSVD};
   end

   // ----------------------------------------------------------------
   // Counter and timer control/status
   // ----------------------------------------------------------------
   always_comb begin
      pre_d     = pre_q + 1'b1;
      cnt_d     = cnt_q;
      ctrl_d    = ctrl_q;
      ovf_arm_d = ovf_arm_q;
      // Counter write or increment
      if (cnt_wr) begin
         cnt_d = bus_req.wdata[7:0];
      end else if (ctrl_q.en && tick) begin
         cnt_d = cnt_q + 8'h01;
      end
      // Control write, flag only cleared when armed
      if (csr_wr) begin
         ctrl_d.mode = bus_req.wdata[WIT_MODE_BIT];
         ctrl_d.en   = bus_req.wdata[WIT_EN_BIT];
         ctrl_d.cks  = bus_req.wdata[2:0];
         if (!bus_req.wdata[WIT_OVF_BIT] && ovf_arm_q) begin
            ctrl_d.ovf = 1'b0;
         end
         ovf_arm_d = 1'b0;
      end
      // Reading the flag as one arms the clear
      if (bus_req.rd && bus_req.sel == WIT_SEL_CSR && ctrl_q.ovf) begin
         ovf_arm_d = 1'b1;
      end
      // Disabled counter stays at zero
      if (!ctrl_d.en) begin
         cnt_d = WIT_CNT_RESET;
      end
      // Set wins over clear
      if (ovf_evt) begin
         ctrl_d.ovf = 1'b1;
      end
      // Watchdog overflow or internal reset clears counter and control
      if (wd_ovf || st_q == WIT_ST_HOLD) begin
         cnt_d     = WIT_CNT_RESET;
         ctrl_d    = WIT_CTRL_RESET;
         ovf_arm_d = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Reset control/status, survives internal reset
   // ----------------------------------------------------------------
   always_comb begin
      rst_d       = rst_q;
      wdovf_arm_d = wdovf_arm_q;
      if (rsten_wr) begin
         rst_d.rsten = bus_req.wdata[WIT_RSTEN_BIT];
         rst_d.rtype = bus_req.wdata[WIT_RTYPE_BIT];
      end
      if (wdovf_wr) begin
         if (!bus_req.wdata[WIT_WDOVF_BIT] && wdovf_arm_q) begin
            rst_d.wdovf = 1'b0;
         end
         wdovf_arm_d = 1'b0;
      end
      // Reads not acknowledged during lockout
      if (bus_req.rd && bus_req.sel == WIT_SEL_RST && rst_q.wdovf
          && st_q == WIT_ST_NORMAL) begin
         wdovf_arm_d = 1'b1;
      end
      // Set wins over clear; interval overflow never sets it
      if (wd_ovf) begin
         rst_d.wdovf = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Overflow sequencing: chip reset hold and write lockout
   // ----------------------------------------------------------------
   always_comb begin
      st_d  = st_q;
      tmr_d = tmr_q + 1'b1;
      unique case (st_q)
         WIT_ST_NORMAL: begin
            tmr_d = '0;
            if (wd_ovf) begin
               st_d = rst_q.rsten ? WIT_ST_HOLD : WIT_ST_LOCK;
            end
         end
         WIT_ST_HOLD: begin
            if (int'(tmr_q) == WIT_RST_HOLD_CYCLES - 1) begin
               st_d = WIT_ST_NORMAL;
            end
         end
         WIT_ST_LOCK: begin
            if (int'(tmr_q) == WIT_LOCK_CYCLES - 1) begin
               st_d = WIT_ST_NORMAL;
            end
         end
      endcase
      chip_reset_d = (st_d == WIT_ST_HOLD);
      irq_d        = ctrl_d.ovf && !ctrl_d.mode;
   end

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   always_comb begin
      rdata_d = rdata_q;
      if (bus_req.rd) begin
         unique case (bus_req.sel)
            WIT_SEL_CSR: rdata_d = ctrl_rd;
            WIT_SEL_CNT: rdata_d = cnt_q;
            WIT_SEL_RST: rdata_d = rst_rd;
            default:     rdata_d = 8'h00;  // Unmapped select
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Registers; the pin reset clears everything
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pre_q          <= '0;
         cnt_q          <= WIT_CNT_RESET;
         ctrl_q         <= WIT_CTRL_RESET;
         rst_q          <= '{wdovf: WIT_RCTL_RESET[WIT_WDOVF_BIT],
                             rsten: WIT_RCTL_RESET[WIT_RSTEN_BIT],
                             rtype: WIT_RCTL_RESET[WIT_RTYPE_BIT]};
         ovf_arm_q      <= 1'b0;
         wdovf_arm_q    <= 1'b0;
         st_q           <= WIT_ST_NORMAL;
         tmr_q          <= '0;
         rdata_q        <= 8'h00;
         chip_reset_q   <= 1'b0;
         interval_irq_q <= 1'b0;
      end else begin
         pre_q          <= pre_d;
         cnt_q          <= cnt_d;
         ctrl_q         <= ctrl_d;
         rst_q          <= rst_d;
         ovf_arm_q      <= ovf_arm_d;
         wdovf_arm_q    <= wdovf_arm_d;
         st_q           <= st_d;
         tmr_q          <= tmr_d;
         rdata_q        <= rdata_d;
         chip_reset_q   <= chip_reset_d;
         interval_irq_q <= irq_d;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   logic [WIT_TMR_W-1:0] rst_len_q;  // Cycles the reset request has stood

   // Reset width counter for checking
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rst_len_q <= '0;
      end else begin
         rst_len_q <= chip_reset_q ? rst_len_q + 1'b1 : '0;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   sequence s_wd_ovf_reset_enable_bit;
      wd_ovf && rst_q.rsten;
   endsequence

   sequence s_reset_window;
      chip_reset_q [*8];
   endsequence

   AST_CNT_ZERO_OFF: assert property (!ctrl_q.en |-> cnt_q == 8'h00)
      else $error("Counter not zero while disabled");
   // A mode change written in the overflow cycle legally masks the interrupt
   AST_OVF_SET: assert property (
      ovf_evt && !ctrl_q.mode && !csr_wr |=> ctrl_q.ovf && interval_irq_q)
      else $error("Interval overflow did not set flag and interrupt");
   AST_OVF_CLR: assert property ($fell(ctrl_q.ovf) |-> $past(ovf_arm_q || wd_ovf))
      else $error("Overflow flag cleared without read first");
   AST_WDOVF_SET: assert property ($rose(rst_q.wdovf) |-> $past(ovf_evt && ctrl_q.mode))
      else $error("Watchdog flag set outside watchdog overflow");
   AST_WDOVF_CLR: assert property ($fell(rst_q.wdovf) |-> $past(wdovf_arm_q && wdovf_wr))
      else $error("Watchdog flag cleared without read first");
   AST_RST_START: assert property (s_wd_ovf_reset_enable_bit |=> s_reset_window)
      else $error("Internal reset not raised on watchdog overflow");
   AST_RST_WIDTH: assert property (
      $fell(chip_reset_q) |-> int'(rst_len_q) == WIT_RST_HOLD_CYCLES)
      else $error("Internal reset width wrong");
   AST_NO_CHIP_RST: assert property (
      wd_ovf && !rst_q.rsten |=> !chip_reset_q && cnt_q == 8'h00 && ctrl_q == WIT_CTRL_RESET)
      else $error("Overflow without reset enable misbehaved");
   AST_WR_PRIO: assert property (
      cnt_wr && ctrl_q.en && !wd_ovf |=> cnt_q == $past(bus_req.wdata[7:0]))
      else $error("Counter write lost to increment");
   AST_BYTE_IGN: assert property (
      bus_req.wr_byte && !bus_req.wr_word |=> $stable({rst_q.rsten, rst_q.rtype}))
      else $error("Byte write changed reset control");
   AST_IRQ_LEVEL: assert property (interval_irq_q |-> ctrl_q.ovf && !ctrl_q.mode)
      else $error("Interrupt without interval overflow flag");

endmodule

// File: dv/tb_top.sv
`timescale 1ns/1ps
module tb_top
   import wit_pkg::*;
;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic             clk;              // System clock
   logic             resetn;           // External reset pin
   wit_bus_req_type  bus_req;          // Register access request
   logic      [7:0]  rdata_q;          // Read data from block
   logic             chip_reset_q;     // Internal reset request
   logic             interval_irq_q;   // Interval interrupt level
   int               mismatches;       // Failed comparisons
   int               samples_checked;  // All comparisons
   logic             rst_seen = 1'b0;  // Internal reset ever raised
   int               n;                // Cycle counter for waits
   int               d;                // Divider under test
   logic      [7:0]  rv;               // Last read value
   int               divs [8] = '{2, 64, 8, 32, 2048, 256, 512, 1024};  // Divider per code

   wit_watchdog_unit dut (
      .clk            (clk),
      .resetn         (resetn),
      .bus_req        (bus_req),
      .rdata_q        (rdata_q),
      .chip_reset_q   (chip_reset_q),
      .interval_irq_q (interval_irq_q)
   );

   // ----------------------------------------------------------------
   // Clock, watchdog and reset monitor
   // ----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // Cuts a hang well beyond the expected run length
   initial begin
      #240000;
      mismatches++;
      final_report();
   end

   // Notes any internal reset pulse
   always @(posedge clk) begin
      if (chip_reset_q === 1'b1) begin
         rst_seen <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   // Compares and counts
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR at %0t ns: seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   // One read strobe, data taken once settled
   task automatic reg_rd(input logic [1:0] sel, output logic [7:0] val);
      @(negedge clk);
      bus_req.rd  = 1'b1;
      bus_req.sel = sel;
      @(negedge clk);
      bus_req.rd  = 1'b0;
      @(negedge clk);
      val = rdata_q;
   endtask

   // Read and compare
   task automatic rd_chk(input logic [1:0] sel, input logic [7:0] exp);
      logic [7:0] v;
      reg_rd(sel, v);
      check(v, exp);
   endtask

   // Keyed write, word or byte strobe
   task automatic reg_wr(input logic [1:0] sel, input logic [7:0] key,
                         input logic [7:0] data, input logic byte_wr = 1'b0);
      @(negedge clk);
      bus_req.wr_word = ~byte_wr;
      bus_req.wr_byte = byte_wr;
      bus_req.sel     = sel;
      bus_req.wdata   = {key, data};
      @(negedge clk);
      bus_req.wr_word = 1'b0;
      bus_req.wr_byte = 1'b0;
   endtask

   // Bounded wait on a level
   task automatic wait_hi(input int which, input int limit, output int cnt);
      cnt = 0;
      while (((which == 0) ? interval_irq_q : chip_reset_q) !== 1'b1 && cnt < limit) begin
         @(negedge clk);
         cnt++;
      end
   endtask

   // Verdict
   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Test sequence
   // ----------------------------------------------------------------
   initial begin
      resetn          = 1'b0;
      bus_req         = '0;
      mismatches      = 0;
      samples_checked = 0;
      repeat (16) @(negedge clk);
      resetn = 1'b1;
      // Reset images and unmapped slot
      check({chip_reset_q, interval_irq_q}, 16'h0);
      rd_chk(2'h0, 8'h18);
      rd_chk(2'h1, 8'h00);
      rd_chk(2'h2, 8'h1f);
      rd_chk(2'h3, 8'h00);
      // Byte write, wrong key, counter write while stopped
      reg_wr(2'h0, 8'ha5, 8'h60, 1'b1);
      rd_chk(2'h0, 8'h18);
      reg_wr(2'h0, 8'h3c, 8'h60);
      rd_chk(2'h0, 8'h18);
      reg_wr(2'h0, 8'h5a, 8'h77);
      rd_chk(2'h1, 8'h00);
      // Counter write while running on the slowest tap
      reg_wr(2'h0, 8'ha5, 8'h3c);
      rd_chk(2'h0, 8'h3c);
      reg_wr(2'h0, 8'h5a, 8'h77);
      reg_rd(2'h1, rv);
      check((rv === 8'h77) || (rv === 8'h78), 16'h1);
      reg_wr(2'h0, 8'ha5, 8'h00);
      rd_chk(2'h1, 8'h00);
      // Interval mode: every clock select code, overflow timing and flag clear
      for (int i = 0; i < 8; i++) begin
         d = divs[i];
         reg_wr(2'h0, 8'ha5, 8'h20 | 8'(i));
         reg_wr(2'h0, 8'h5a, 8'hfe);
         wait_hi(0, 3 * d + 10, n);
         check((n >= d - 2) && (n <= 2 * d + 3), 16'h1);
         if (i == 0) begin
            // Unarmed write with a one leaves the flag set
            reg_wr(2'h0, 8'ha5, 8'ha0);
            check(interval_irq_q, 16'h1);
         end
         rd_chk(2'h0, 8'hb8 | 8'(i));
         rd_chk(2'h2, 8'h1f);
         reg_wr(2'h0, 8'ha5, 8'h00);
         repeat (2) @(negedge clk);
         check(interval_irq_q, 16'h0);
         rd_chk(2'h0, 8'h18);
      end
      // Watchdog mode without reset enable
      reg_wr(2'h0, 8'ha5, 8'h60);
      reg_wr(2'h0, 8'h5a, 8'hfe);
      repeat (10) @(negedge clk);
      rd_chk(2'h2, 8'h9f);
      rd_chk(2'h0, 8'h18);
      rd_chk(2'h1, 8'h00);
      reg_wr(2'h0, 8'ha5, 8'h20);
      rd_chk(2'h0, 8'h18);
      check({rst_seen, interval_irq_q}, 16'h0);
      repeat (140) @(negedge clk);
      rd_chk(2'h2, 8'h9f);
      reg_wr(2'h2, 8'ha5, 8'h80);
      rd_chk(2'h2, 8'h9f);
      rd_chk(2'h2, 8'h9f);
      reg_wr(2'h2, 8'ha5, 8'h00);
      rd_chk(2'h2, 8'h1f);
      // Watchdog mode with reset enable: pulse width and kept register
      reg_wr(2'h2, 8'h5a, 8'h40);
      rd_chk(2'h2, 8'h5f);
      reg_wr(2'h0, 8'ha5, 8'h60);
      reg_wr(2'h0, 8'h5a, 8'hfe);
      wait_hi(1, 50, n);
      check(n < 50, 16'h1);
      n = 0;
      while (chip_reset_q === 1'b1 && n < 600) begin
         @(negedge clk);
         n++;
      end
      check(n, 16'd518);
      repeat (140) @(negedge clk);
      rd_chk(2'h2, 8'hdf);
      rd_chk(2'h0, 8'h18);
      rd_chk(2'h1, 8'h00);
      // Pin reset during the internal reset wins
      reg_wr(2'h0, 8'ha5, 8'h60);
      reg_wr(2'h0, 8'h5a, 8'hfe);
      wait_hi(1, 50, n);
      check(n < 50, 16'h1);
      repeat (5) @(negedge clk);
      resetn = 1'b0;
      repeat (2) @(negedge clk);
      check(chip_reset_q, 16'h0);
      resetn = 1'b1;
      rd_chk(2'h2, 8'h1f);
      rd_chk(2'h0, 8'h18);
      final_report();
   end
endmodule
